// file: eeelp_lp_model.sv
// link partner model: recovered line clock and received code groups
// assumes the bench calls send and quiet from one process at a time
`timescale 1ns/10ps
`default_nettype none
module eeelp_lp_model (
	// line toward the block
	output logic line_clk,
	output logic [4:0] rx_code
);
	logic run;
	initial begin
		line_clk = 1'b0;
		rx_code = 5'h1f;
		run = 1'b1;
	end
	// 160 ns clock; it stands still while the partner is quiet
	always #80 line_clk = run ? ~line_clk : 1'b0;
	// one group per clock, changed just after the edge
	task send(input logic [4:0] code, input int n);
		repeat (n) begin
			@(posedge line_clk);
			rx_code <= code;
		end
	endtask : send
	// quiet line: no clock, junk on the data, resume with a given group
	task quiet(input int ns, input logic [4:0] resume);
		@(posedge line_clk);
		run = 1'b0;
		rx_code <= ~rx_code;
		// off the clock grid, so restarting never races the toggling process
		#(ns + 40);
		rx_code = resume;
		run = 1'b1;
	endtask : quiet
endmodule : eeelp_lp_model
`default_nettype wire

// file: eeelp_pcs.sv
// low-power idle coding logic: transmit sequencer, receive decoder and opcodes
// assumes mac transmit pins sampled on core_clk, receive groups arrive on line_clk
`timescale 1ns/10ps
`default_nettype none
module eeelp_pcs #(
	parameter logic [eeelp_pkg::TMR_W-1:0] SLEEP_CYC = eeelp_pkg::TMR_W'(eeelp_pkg::SLEEP_CYC),
	parameter logic [eeelp_pkg::TMR_W-1:0] QUIET_CYC = eeelp_pkg::TMR_W'(eeelp_pkg::QUIET_CYC),
	parameter logic [eeelp_pkg::TMR_W-1:0] REFRESH_CYC =
		eeelp_pkg::TMR_W'(eeelp_pkg::REFRESH_CYC),
	parameter logic [eeelp_pkg::TMR_W-1:0] RX_SLEEP_MAX_CYC =
		eeelp_pkg::TMR_W'(eeelp_pkg::RX_SLEEP_MAX_CYC),
	parameter logic [eeelp_pkg::TMR_W-1:0] RX_QUIET_MAX_CYC =
		eeelp_pkg::TMR_W'(eeelp_pkg::RX_QUIET_MAX_CYC)
) (
	// core clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// link receive clock, recovered from the partner
	input wire logic line_clk,
	// mac transmit side
	input wire logic tx_en,
	input wire logic tx_er,
	input wire logic [3:0] txd,
	// mac receive side
	output logic rx_dv,
	output logic rx_er,
	output logic [3:0] rxd,
	// configuration levels
	input wire logic speed_100,
	input wire logic rgmii_mode,
	input wire logic eee_adv_local,
	input wire logic eee_adv_partner,
	// transmit line
	output logic [4:0] tx_code,
	output logic tx_drv_idle,
	output logic tx_amp_reduce,
	// receive line, on line_clk
	input wire logic [4:0] rx_code,
	// status toward clock control
	output logic tx_lpi,
	output logic rx_lpi,
	output logic rx_clk_stop_ok,
	output logic tx_clk_stop_ok
);
	import eeelp_pkg::*;

	localparam logic [TMR_W-1:0] WAKE_N = TMR_W'(WAKE_CYC);
	localparam logic [TMR_W-1:0] RX_WAKE_N = TMR_W'(RX_WAKE_MIN_CYC);
	localparam logic [TMR_W-1:0] RX_GAP_N = TMR_W'(RX_GAP_CYC);
	localparam logic [TMR_W-1:0] TMR_ONE = TMR_W'(1);

	// ---------------- transmit, core domain ----------------

	eeelp_tx_st_t tx_st_q, tx_st_d;
	logic [TMR_W-1:0] tx_tmr_q, tx_tmr_d;
	logic [1:0] tx_tail_q, tx_tail_d;
	logic tx_en_q;
	logic tx_sop_q;
	logic [4:0] tx_code_q, tx_code_d;
	logic tx_drv_idle_q;
	logic tx_amp_q;
	logic tx_lpi_q;
	logic tx_stop_q;
	logic [4:0] data_cg;

	// opcode decode; local and partner ability and speed gate the request
	wire lpi_opcode = !tx_en && tx_er && (txd == NIB_LPI);
	wire eee_ok = eee_adv_local && eee_adv_partner;
	wire lpi_req = lpi_opcode && eee_ok && speed_100;
	wire tx_tmr_done = (tx_tmr_q == TMR_ONE);
	wire tx_sof = tx_en && !tx_en_q;
	wire tx_eof = !tx_en && tx_en_q;

	// nibble to code group
	always_comb begin
		case (txd)
			4'h0: data_cg = 5'h1e;
			4'h1: data_cg = 5'h09;
			4'h2: data_cg = 5'h14;
			4'h3: data_cg = 5'h15;
			4'h4: data_cg = 5'h0a;
			4'h5: data_cg = 5'h0b;
			4'h6: data_cg = 5'h0e;
			4'h7: data_cg = 5'h0f;
			4'h8: data_cg = 5'h12;
			4'h9: data_cg = 5'h13;
			4'ha: data_cg = 5'h16;
			4'hb: data_cg = 5'h17;
			4'hc: data_cg = 5'h1a;
			4'hd: data_cg = 5'h1b;
			4'he: data_cg = 5'h1c;
			default: data_cg = 5'h1d;
		endcase
	end

	// line state sequencer; the opcode is static so no edge detection is needed
	always_comb begin
		tx_st_d = tx_st_q;
		tx_tmr_d = (tx_tmr_q > TMR_ONE) ? tx_tmr_q - TMR_ONE : tx_tmr_q;
		case (tx_st_q)
			EEELP_TX_ACTIVE: begin
				// only from the gap, so a frame in flight is never cut
				if (lpi_req && !tx_en_q && (tx_tail_q == 2'd0)) begin
					tx_st_d = EEELP_TX_SLEEP;
					tx_tmr_d = SLEEP_CYC;
				end
			end
			EEELP_TX_SLEEP: begin
				if (!lpi_req) begin
					tx_st_d = EEELP_TX_WAKE;
					tx_tmr_d = WAKE_N;
				end else if (tx_tmr_done) begin
					tx_st_d = EEELP_TX_QUIET;
					tx_tmr_d = QUIET_CYC;
				end
			end
			EEELP_TX_QUIET: begin
				if (!lpi_req) begin
					tx_st_d = EEELP_TX_WAKE;
					tx_tmr_d = WAKE_N;
				end else if (tx_tmr_done) begin
					tx_st_d = EEELP_TX_REFRESH;
					tx_tmr_d = REFRESH_CYC;
				end
			end
			EEELP_TX_REFRESH: begin
				if (!lpi_req) begin
					tx_st_d = EEELP_TX_WAKE;
					tx_tmr_d = WAKE_N;
				end else if (tx_tmr_done) begin
					tx_st_d = EEELP_TX_QUIET;
					tx_tmr_d = QUIET_CYC;
				end
			end
			EEELP_TX_WAKE: begin
				if (tx_tmr_done) begin
					tx_st_d = EEELP_TX_ACTIVE;
				end
			end
			default: begin
				tx_st_d = EEELP_TX_ACTIVE;
			end
		endcase
	end

	// code group choice; delimiters replace the first two nibbles and follow the last one
	always_comb begin
		tx_code_d = CG_IDLE;
		tx_tail_d = 2'd0;
		case (tx_st_q)
			EEELP_TX_ACTIVE: begin
				if (tx_sof) begin
					tx_code_d = CG_SSD_J;
				end else if (tx_en && tx_sop_q) begin
					tx_code_d = CG_SSD_K;
				end else if (tx_en && tx_er) begin
					tx_code_d = CG_TXERR;
				end else if (tx_en) begin
					tx_code_d = data_cg;
				end else if (tx_eof) begin
					tx_code_d = CG_ESD_T;
					tx_tail_d = 2'd1;
				end else if (tx_tail_q == 2'd1) begin
					tx_code_d = CG_ESD_R;
				end
			end
			EEELP_TX_SLEEP, EEELP_TX_REFRESH: tx_code_d = CG_SLEEP;
			EEELP_TX_QUIET: tx_code_d = CG_SLEEP;
			EEELP_TX_WAKE: tx_code_d = CG_IDLE;
			default: tx_code_d = CG_IDLE;
		endcase
	end

	// transmit state and timer
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tx_st_q <= EEELP_TX_ACTIVE;
			tx_tmr_q <= '0;
		end else begin
			tx_st_q <= tx_st_d;
			tx_tmr_q <= tx_tmr_d;
		end
	end

	// transmit line registers; outputs come straight from these
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tx_en_q <= 1'b0;
			tx_sop_q <= 1'b0;
			tx_tail_q <= 2'd0;
			tx_code_q <= CG_IDLE;
			tx_drv_idle_q <= 1'b0;
			tx_amp_q <= 1'b0;
			tx_lpi_q <= 1'b0;
			tx_stop_q <= 1'b0;
		end else begin
			tx_en_q <= tx_en;
			tx_sop_q <= tx_sof;
			tx_tail_q <= tx_tail_d;
			tx_code_q <= tx_code_d;
			tx_drv_idle_q <= (tx_st_d == EEELP_TX_QUIET);
			tx_amp_q <= !speed_100 && eee_adv_local;
			tx_lpi_q <= (tx_st_d != EEELP_TX_ACTIVE) && (tx_st_d != EEELP_TX_WAKE);
			// mii needs our transmit clock to take the opcode in
			tx_stop_q <= rgmii_mode && (tx_st_d == EEELP_TX_QUIET);
		end
	end

	// ---------------- receive, line domain ----------------

	logic lrst_s1_q, lrst_s2_q;
	logic [4:0] rx_cg_q;
	logic [6:0] sym_word_q;
	logic sym_tgl_q;
	eeelp_sym_t rx_cls;
	logic [3:0] rx_nib;

	// reset carried into the line domain; the clock may be stopped meanwhile
	always_ff @(posedge line_clk) begin
		lrst_s1_q <= sys_rst;
		lrst_s2_q <= lrst_s1_q;
	end

	// group classification and data decode
	always_comb begin
		rx_cls = EEELP_SYM_DATA;
		rx_nib = 4'h0;
		case (rx_cg_q)
			5'h1e: rx_nib = 4'h0;
			5'h09: rx_nib = 4'h1;
			5'h14: rx_nib = 4'h2;
			5'h15: rx_nib = 4'h3;
			5'h0a: rx_nib = 4'h4;
			5'h0b: rx_nib = 4'h5;
			5'h0e: rx_nib = 4'h6;
			5'h0f: rx_nib = 4'h7;
			5'h12: rx_nib = 4'h8;
			5'h13: rx_nib = 4'h9;
			5'h16: rx_nib = 4'ha;
			5'h17: rx_nib = 4'hb;
			5'h1a: rx_nib = 4'hc;
			5'h1b: rx_nib = 4'hd;
			5'h1c: rx_nib = 4'he;
			5'h1d: rx_nib = 4'hf;
			CG_IDLE: rx_cls = EEELP_SYM_IDLE;
			CG_SLEEP: rx_cls = EEELP_SYM_SLEEP;
			CG_SSD_J, CG_SSD_K: begin
				rx_cls = EEELP_SYM_SSD;
				rx_nib = NIB_SSD;
			end
			CG_ESD_T, CG_ESD_R: rx_cls = EEELP_SYM_ESD;
			CG_TXERR: rx_cls = EEELP_SYM_TXERR;
			default: rx_cls = EEELP_SYM_BAD;
		endcase
	end

	// one word per group, announced by a toggle
	always_ff @(posedge line_clk) begin
		if (lrst_s2_q) begin
			rx_cg_q <= CG_IDLE;
			sym_word_q <= 7'h00;
			sym_tgl_q <= 1'b0;
		end else begin
			rx_cg_q <= rx_code;
			sym_word_q <= {rx_cls, rx_nib};
			sym_tgl_q <= !sym_tgl_q;
		end
	end

	// ---------------- receive, core domain ----------------

	logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
	logic [6:0] sym_q;
	logic sym_v_q;
	eeelp_rx_st_t rx_st_q, rx_st_d;
	logic [TMR_W-1:0] rx_tmr_q, rx_tmr_d;
	logic [TMR_W-1:0] gap_q;
	logic in_frame_q;
	logic rx_dv_q, rx_er_q;
	logic [3:0] rxd_q;
	logic rx_lpi_q;
	logic rx_stop_q;

	// word is captured well after the toggle and well before the next one
	wire sym_evt = tgl_s2_q ^ tgl_s3_q;
	wire [2:0] s_cls = sym_q[6:4];
	wire [3:0] s_nib = sym_q[3:0];
	wire s_sleep = sym_v_q && (s_cls == EEELP_SYM_SLEEP);
	wire s_idle = sym_v_q && (s_cls == EEELP_SYM_IDLE);
	wire s_frame = sym_v_q && ((s_cls == EEELP_SYM_SSD) || (s_cls == EEELP_SYM_DATA));
	wire line_silent = (gap_q >= RX_GAP_N);
	wire rx_tmr_hit = (rx_tmr_q >= RX_SLEEP_MAX_CYC);

	// toggle synchroniser and word capture
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
			sym_q <= 7'h00;
			sym_v_q <= 1'b0;
			gap_q <= '0;
		end else begin
			tgl_s1_q <= sym_tgl_q;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
			sym_v_q <= sym_evt;
			if (sym_evt) begin
				sym_q <= sym_word_q;
			end
			gap_q <= sym_evt ? '0 : ((gap_q == RX_QUIET_MAX_CYC) ? gap_q : gap_q + TMR_ONE);
		end
	end

	// partner low-power tracking, independent of the transmit sequencer
	always_comb begin
		rx_st_d = rx_st_q;
		rx_tmr_d = rx_tmr_q + TMR_ONE;
		case (rx_st_q)
			EEELP_RX_ACTIVE: begin
				rx_tmr_d = '0;
				if (s_sleep && eee_ok && speed_100 && !in_frame_q) begin
					rx_st_d = EEELP_RX_SLEEP;
				end
			end
			EEELP_RX_SLEEP: begin
				if (s_frame || rx_tmr_hit) begin
					rx_st_d = EEELP_RX_ACTIVE;
				end else if (line_silent) begin
					rx_st_d = EEELP_RX_QUIET;
					rx_tmr_d = '0;
				end
			end
			EEELP_RX_QUIET: begin
				if (s_sleep) begin // refresh burst
					rx_st_d = EEELP_RX_SLEEP;
					rx_tmr_d = '0;
				end else if (s_idle) begin
					rx_st_d = EEELP_RX_WAKE;
					rx_tmr_d = '0;
				end else if (s_frame || (rx_tmr_q >= RX_QUIET_MAX_CYC)) begin
					rx_st_d = EEELP_RX_ACTIVE;
				end
			end
			EEELP_RX_WAKE: begin
				if (s_frame || (rx_tmr_q >= RX_WAKE_N)) begin
					rx_st_d = EEELP_RX_ACTIVE;
				end else if (s_sleep) begin
					rx_st_d = EEELP_RX_SLEEP;
					rx_tmr_d = '0;
				end
			end
			default: rx_st_d = EEELP_RX_ACTIVE;
		endcase
	end

	wire rx_in_lpi = (rx_st_d != EEELP_RX_ACTIVE) && (rx_st_d != EEELP_RX_WAKE);

	// receive state and frame tracking
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rx_st_q <= EEELP_RX_ACTIVE;
			rx_tmr_q <= '0;
			in_frame_q <= 1'b0;
		end else begin
			rx_st_q <= rx_st_d;
			rx_tmr_q <= rx_tmr_d;
			if (sym_v_q && (s_cls == EEELP_SYM_SSD)) begin
				in_frame_q <= 1'b1;
			end else if (sym_v_q && ((s_cls == EEELP_SYM_ESD) || (s_cls == EEELP_SYM_IDLE))) begin
				in_frame_q <= 1'b0;
			end
		end
	end

	// receive opcodes toward the mac, held between groups
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rx_dv_q <= 1'b0;
			rx_er_q <= 1'b0;
			rxd_q <= NIB_IFG;
			rx_lpi_q <= 1'b0;
			rx_stop_q <= 1'b0;
		end else begin
			rx_lpi_q <= rx_in_lpi;
			rx_stop_q <= rx_in_lpi && (rx_st_d == EEELP_RX_QUIET);
			if (rx_in_lpi) begin
				rx_dv_q <= 1'b0;
				rx_er_q <= 1'b1;
				rxd_q <= NIB_LPI;
			end else if (sym_v_q) begin
				if (in_frame_q || (s_cls == EEELP_SYM_SSD)) begin
					rx_dv_q <= (s_cls != EEELP_SYM_ESD) && (s_cls != EEELP_SYM_IDLE);
					rx_er_q <= (s_cls == EEELP_SYM_TXERR) || (s_cls == EEELP_SYM_BAD);
					rxd_q <= s_nib;
				end else if (s_cls == EEELP_SYM_BAD) begin
					rx_dv_q <= 1'b0;
					rx_er_q <= 1'b1;
					rxd_q <= NIB_FCAR;
				end else begin
					rx_dv_q <= 1'b0;
					rx_er_q <= 1'b0;
					rxd_q <= NIB_IFG;
				end
			end else if (!rx_in_lpi && rx_lpi_q) begin
				rx_dv_q <= 1'b0; // leaving low-power: back to inter-frame
				rx_er_q <= 1'b0;
				rxd_q <= NIB_IFG;
			end
		end
	end

	// outputs
	assign tx_code = tx_code_q;
	assign tx_drv_idle = tx_drv_idle_q;
	assign tx_amp_reduce = tx_amp_q;
	assign tx_lpi = tx_lpi_q;
	assign tx_clk_stop_ok = tx_stop_q;
	assign rx_dv = rx_dv_q;
	assign rx_er = rx_er_q;
	assign rxd = rxd_q;
	assign rx_lpi = rx_lpi_q;
	assign rx_clk_stop_ok = rx_stop_q;
endmodule : eeelp_pcs
`default_nettype wire

// file: eeelp_pcs_bench.sv
// self-checking bench for the low-power idle coding block
// assumes shortened sleep, quiet and refresh counts set below
`timescale 1ns/10ps
`default_nettype none
module eeelp_pcs_bench;
	import eeelp_pkg::*;
	localparam int SLP = 200;
	localparam int QUI = 2000;
	localparam int REF = 200;
	logic core_clk = 1'b0;
	logic sys_rst, tx_en, tx_er, speed_100, rgmii_mode, eee_adv_local, eee_adv_partner;
	logic [3:0] txd, rxd;
	logic rx_dv, rx_er, tx_drv_idle, tx_amp_reduce, tx_lpi, rx_lpi, rx_clk_stop_ok;
	logic tx_clk_stop_ok, line_clk;
	logic [4:0] tx_code, rx_code;
	logic [4:0] tq[$];
	logic [5:0] rq[$];
	logic [5:0] rx_last = 6'h00;
	integer seed = 50;
	int n_fail = 0;
	int samples_checked = 0;
	logic [4:0] enc[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	always #12.5 core_clk = ~core_clk;
	eeelp_pcs #(.SLEEP_CYC(SLP), .QUIET_CYC(QUI), .REFRESH_CYC(REF), .RX_SLEEP_MAX_CYC(400),
		.RX_QUIET_MAX_CYC(5000)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.line_clk(line_clk), .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .rx_dv(rx_dv),
		.rx_er(rx_er), .rxd(rxd), .speed_100(speed_100), .rgmii_mode(rgmii_mode),
		.eee_adv_local(eee_adv_local), .eee_adv_partner(eee_adv_partner),
		.tx_code(tx_code), .tx_drv_idle(tx_drv_idle), .tx_amp_reduce(tx_amp_reduce),
		.rx_code(rx_code), .tx_lpi(tx_lpi), .rx_lpi(rx_lpi),
		.rx_clk_stop_ok(rx_clk_stop_ok), .tx_clk_stop_ok(tx_clk_stop_ok));
	eeelp_lp_model lp (.line_clk(line_clk), .rx_code(rx_code));
	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task finish_test;
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	task drive(input logic en, input logic er, input logic [3:0] d);
		@(posedge core_clk);
		tx_en <= en;
		tx_er <= er;
		txd <= d;
	endtask : drive
	// preamble pair becomes the start delimiter; third data nibble flagged bad
	task send_frame(input int n);
		logic [3:0] d;
		tq.push_back(CG_SSD_J);
		tq.push_back(CG_SSD_K);
		drive(1'b1, 1'b0, 4'h5);
		drive(1'b1, 1'b0, 4'h5);
		for (int i = 0; i < n; i++) begin
			d = 4'($random(seed));
			tq.push_back(i == 2 ? CG_TXERR : enc[d]);
			drive(1'b1, i == 2, d);
		end
		tq.push_back(CG_ESD_T);
		tq.push_back(CG_ESD_R);
		drive(1'b0, 1'b0, 4'h0);
	endtask : send_frame
	// sleep, quiet, one refresh, then drop the request early in the next quiet
	task tx_lpi_seq;
		repeat (SLP + REF) tq.push_back(CG_SLEEP);
		drive(1'b0, 1'b1, NIB_LPI);
		repeat (SLP + QUI / 2) @(posedge core_clk);
		@(negedge core_clk);
		chk("tx_clk_stop_ok", 8'(tx_clk_stop_ok), 8'h01);
		repeat (QUI / 2 + REF + 100) @(posedge core_clk);
		drive(1'b0, 1'b0, 4'h0);
		repeat (2) @(negedge core_clk);
		chk("tx_lpi", 8'(tx_lpi), 8'h00);
	endtask : tx_lpi_seq
	// partner frame, bad group, sleep, quiet, refresh, frame
	task rx_seq;
		rq = '{6'h25, 6'h23, 6'h27, 6'h00, 6'h1e, 6'h00, 6'h11, 6'h25, 6'h2a, 6'h00};
		lp.send(CG_SSD_J, 1);
		lp.send(CG_SSD_K, 1);
		lp.send(5'h15, 1);
		lp.send(5'h0f, 1);
		lp.send(CG_ESD_T, 1);
		lp.send(CG_ESD_R, 1);
		lp.send(CG_IDLE, 10);
		lp.send(5'h08, 3);
		lp.send(CG_IDLE, 10);
		lp.send(CG_SLEEP, 20);
		fork
			lp.quiet(20000, CG_SLEEP);
			begin
				#10000;
				@(negedge core_clk);
				chk("rx_lpi", 8'(rx_lpi), 8'h01);
				chk("rx_clk_stop_ok", 8'(rx_clk_stop_ok), 8'h01);
			end
		join
		lp.send(CG_SLEEP, 20);
		lp.send(CG_SSD_J, 1);
		lp.send(CG_SSD_K, 1);
		lp.send(5'h16, 1);
		lp.send(CG_ESD_T, 1);
		lp.send(CG_ESD_R, 1);
		lp.send(CG_IDLE, 10);
	endtask : rx_seq
	// transmit results: every non-idle group on a driven line is expected
	always @(negedge core_clk) begin
		if (!sys_rst && !tx_drv_idle && tx_code !== CG_IDLE) begin
			chk("tx_code", 8'(tx_code), tq.size() ? 8'(tq.pop_front()) : 8'hff);
		end
	end
	// receive results: each change of opcode is one expected note
	always @(negedge core_clk) begin
		if (!sys_rst && {rx_dv, rx_er, rxd} !== rx_last) begin
			chk("rx opcode", 8'({rx_dv, rx_er, rxd}), rq.size() ? 8'(rq.pop_front()) : 8'hff);
		end
		rx_last = {rx_dv, rx_er, rxd};
	end
	// run takes about 4200 cycles; one millisecond means a hang
	initial begin
		#1000000;
		n_fail++;
		finish_test;
	end
	initial begin
		sys_rst = 1'b1;
		{tx_en, tx_er, txd} = 6'h00;
		{speed_100, rgmii_mode, eee_adv_local, eee_adv_partner} = 4'hf;
		// the slow line domain needs several of its own edges in reset
		repeat (8) @(posedge line_clk);
		@(posedge core_clk);
		sys_rst <= 1'b0;
		@(negedge core_clk);
		chk("tx_code at reset", 8'(tx_code), 8'(CG_IDLE));
		send_frame(6);
		repeat (10) @(posedge core_clk);
		fork
			tx_lpi_seq();
			rx_seq();
		join
		repeat (1300) @(posedge core_clk);
		send_frame(4);
		// refused: slow link, then partner without the ability
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk);
			speed_100 <= 1'(k);
			eee_adv_partner <= ~1'(k);
			drive(1'b0, 1'b1, NIB_LPI);
			repeat (20) @(negedge core_clk);
			chk("tx_lpi refused", 8'(tx_lpi), 8'h00);
			chk("tx_amp_reduce", 8'(tx_amp_reduce), 8'(k == 0));
			drive(1'b0, 1'b0, 4'h0);
		end
		// mii: low-power still allowed, but our transmit clock must keep running
		rgmii_mode <= 1'b0;
		eee_adv_partner <= 1'b1;
		repeat (SLP) tq.push_back(CG_SLEEP);
		drive(1'b0, 1'b1, NIB_LPI);
		repeat (SLP + 20) @(negedge core_clk);
		chk("tx_drv_idle", 8'(tx_drv_idle), 8'h01);
		chk("tx_clk_stop_ok mii", 8'(tx_clk_stop_ok), 8'h00);
		drive(1'b0, 1'b0, 4'h0);
		repeat (10) @(negedge core_clk);
		chk("tx notes left", 8'(tq.size()), 8'h00);
		chk("rx notes left", 8'(rq.size()), 8'h00);
		finish_test;
	end
endmodule : eeelp_pcs_bench
`default_nettype wire

// file: eeelp_pkg.sv
// constants, code groups and state types of the low-power idle coding logic
// assumes a 40 mhz core clock that also sources the mac transmit clock
package eeelp_pkg;
	localparam int CLK_MHZ = 40;
	localparam int TMR_W = 21;
	// transmit timings, least values so each lands inside its window
	localparam int SLEEP_PERIOD_NS = 200000;
	localparam int QUIET_PERIOD_NS = 20000000;
	localparam int REFRESH_PERIOD_NS = 200000;
	localparam int WAKE_PERIOD_NS = 30000;
	localparam int SLEEP_CYC = (SLEEP_PERIOD_NS * CLK_MHZ + 999) / 1000;
	localparam int QUIET_CYC = (QUIET_PERIOD_NS * CLK_MHZ + 999) / 1000;
	localparam int REFRESH_CYC = (REFRESH_PERIOD_NS * CLK_MHZ + 999) / 1000;
	localparam int WAKE_CYC = (WAKE_PERIOD_NS * CLK_MHZ + 999) / 1000;
	// receive limits: longest accepted times round down
	localparam int RX_SLEEP_MAX_NS = 260000;
	localparam int RX_QUIET_MAX_NS = 26000000;
	localparam int RX_WAKE_MIN_NS = 30000;
	localparam int RX_SLEEP_MAX_CYC = (RX_SLEEP_MAX_NS * CLK_MHZ) / 1000;
	localparam int RX_QUIET_MAX_CYC = (RX_QUIET_MAX_NS * CLK_MHZ) / 1000;
	localparam int RX_WAKE_MIN_CYC = (RX_WAKE_MIN_NS * CLK_MHZ + 999) / 1000;
	// core cycles with no received group before the line counts as quiet
	localparam int RX_GAP_CYC = 64;
	// code groups
	localparam logic [4:0] CG_IDLE = 5'h1f;
	localparam logic [4:0] CG_SLEEP = 5'h00;
	localparam logic [4:0] CG_SSD_J = 5'h18;
	localparam logic [4:0] CG_SSD_K = 5'h11;
	localparam logic [4:0] CG_ESD_T = 5'h0d;
	localparam logic [4:0] CG_ESD_R = 5'h07;
	localparam logic [4:0] CG_TXERR = 5'h04;
	// mii nibbles of interest
	localparam logic [3:0] NIB_LPI = 4'h1;
	localparam logic [3:0] NIB_IFG = 4'h0;
	localparam logic [3:0] NIB_FCAR = 4'he;
	localparam logic [3:0] NIB_SSD = 4'h5;
	// class of a received group
	typedef enum logic [2:0] {
		EEELP_SYM_DATA = 3'h0,
		EEELP_SYM_IDLE = 3'h1,
		EEELP_SYM_SLEEP = 3'h2,
		EEELP_SYM_SSD = 3'h3,
		EEELP_SYM_ESD = 3'h4,
		EEELP_SYM_TXERR = 3'h5,
		EEELP_SYM_BAD = 3'h6
	} eeelp_sym_t;
	typedef enum logic [4:0] {
		EEELP_TX_ACTIVE = 5'b00001,
		EEELP_TX_SLEEP = 5'b00010,
		EEELP_TX_QUIET = 5'b00100,
		EEELP_TX_REFRESH = 5'b01000,
		EEELP_TX_WAKE = 5'b10000
	} eeelp_tx_st_t;
	typedef enum logic [3:0] {
		EEELP_RX_ACTIVE = 4'b0001,
		EEELP_RX_SLEEP = 4'b0010,
		EEELP_RX_QUIET = 4'b0100,
		EEELP_RX_WAKE = 4'b1000
	} eeelp_rx_st_t;
endpackage : eeelp_pkg

// file: eeelp_sva.sv
// checker for the low-power idle coding block, watching top-level ports only
// assumes all watched outputs are registered on core_clk, reset sync high
`timescale 1ns/10ps
`default_nettype none
module eeelp_sva
	import eeelp_pkg::*;
#(
	parameter int SLEEP_CYC = 200,
	parameter int QUIET_CYC = 2000,
	parameter int REFRESH_CYC = 200
) (
	// clocks and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic line_clk,
	// mac side
	input wire logic tx_en,
	input wire logic tx_er,
	input wire logic [3:0] txd,
	input wire logic rx_dv,
	input wire logic rx_er,
	input wire logic [3:0] rxd,
	// configuration
	input wire logic speed_100,
	input wire logic rgmii_mode,
	input wire logic eee_adv_local,
	input wire logic eee_adv_partner,
	// line and status
	input wire logic [4:0] tx_code,
	input wire logic tx_drv_idle,
	input wire logic tx_lpi,
	input wire logic rx_lpi,
	input wire logic rx_clk_stop_ok,
	input wire logic tx_clk_stop_ok
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	// request decode and permission
	wire logic lpi_req = !tx_en && tx_er && txd == NIB_LPI;
	wire logic lpi_ok = speed_100 && eee_adv_local && eee_adv_partner;
	logic [11:0] since_q;
	logic [20:0] burst_q;
	logic [20:0] quiet_q;
	// run lengths; since_q saturates so a fresh active state is recognisable
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			since_q <= 12'hfff;
			burst_q <= '0;
			quiet_q <= '0;
		end else begin
			since_q <= tx_lpi ? 12'h000 : (since_q == 12'hfff ? since_q : since_q + 12'h001);
			burst_q <= (tx_lpi && !tx_drv_idle) ? burst_q + 21'h000001 : '0;
			quiet_q <= tx_drv_idle ? quiet_q + 21'h000001 : '0;
		end
	end
	a_lpi_entry: assert property (lpi_req && lpi_ok && !tx_lpi && since_q == 12'hfff &&
		tx_code == CG_IDLE && !$past(tx_en) |=> tx_lpi ##1 tx_code == CG_SLEEP)
		else $error("low-power request did not start sleep");
	a_lpi_refused: assert property (!lpi_ok && !tx_lpi |=> !tx_lpi)
		else $error("low-power entered without permission");
	a_burst_len: assert property ($rose(tx_drv_idle) |-> burst_q == SLEEP_CYC ||
		burst_q == REFRESH_CYC)
		else $error("sleep or refresh burst has wrong length");
	a_quiet_len: assert property ($fell(tx_drv_idle) && tx_lpi |->
		quiet_q == QUIET_CYC && tx_code == CG_SLEEP)
		else $error("quiet period wrong or not followed by refresh");
	// the group register trails the state by one cycle, so idle shows one later
	a_wake_exit: assert property (tx_lpi && !lpi_req |=> !tx_lpi ##1 tx_code == CG_IDLE)
		else $error("low-power not left at once");
	a_wake_hold: assert property (!tx_lpi && since_q != 12'h000 &&
		since_q < WAKE_CYC |-> tx_code == CG_IDLE)
		else $error("wake idle groups cut short");
	a_frame_start: assert property ($rose(tx_en) && speed_100 && !tx_lpi &&
		since_q == 12'hfff |=> tx_code == CG_SSD_J ##1 tx_code == CG_SSD_K)
		else $error("start delimiter missing");
	a_frame_end: assert property ($fell(tx_en) && speed_100 |=> tx_code == CG_ESD_T
		##1 tx_code == CG_ESD_R ##1 tx_code == CG_IDLE)
		else $error("end delimiter or idle fill missing");
	a_tx_error: assert property (tx_en && tx_er && $past(tx_en, 2) |=> tx_code == CG_TXERR)
		else $error("transmit error group missing");
	a_rx_lpi_code: assert property (rx_lpi |-> !rx_dv && rx_er && rxd == NIB_LPI)
		else $error("partner low-power opcode wrong");
	a_clk_stop: assert property ((rx_clk_stop_ok |-> rx_lpi) and
		(tx_clk_stop_ok |-> $past(rgmii_mode) && tx_drv_idle))
		else $error("clock stop allowed outside quiet");
	// main scenarios reached
	c_quiet: cover property ($rose(tx_drv_idle));
	c_wake: cover property ($fell(tx_lpi));
	c_rx_quiet: cover property ($rose(rx_clk_stop_ok));
endmodule : eeelp_sva
bind eeelp_pcs eeelp_sva #(
	.SLEEP_CYC(SLEEP_CYC), .QUIET_CYC(QUIET_CYC), .REFRESH_CYC(REFRESH_CYC)
) u_sva (
	.core_clk(core_clk), .sys_rst(sys_rst), .line_clk(line_clk), .tx_en(tx_en),
	.tx_er(tx_er), .txd(txd), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd),
	.speed_100(speed_100), .rgmii_mode(rgmii_mode), .eee_adv_local(eee_adv_local),
	.eee_adv_partner(eee_adv_partner), .tx_code(tx_code), .tx_drv_idle(tx_drv_idle),
	.tx_lpi(tx_lpi), .rx_lpi(rx_lpi), .rx_clk_stop_ok(rx_clk_stop_ok),
	.tx_clk_stop_ok(tx_clk_stop_ok)
);
`default_nettype wire
